// ===== core/sswc_cfg.svh
// Timing, address and code constants for the stack sleep and wake control.
`ifndef SSWC_CFG_SVH
`define SSWC_CFG_SVH

`define SSWC_CLK_MHZ        100
`define SSWC_SLEEP_WAIT_US  500
`define SSWC_SLEEP_WAIT_CYC (`SSWC_SLEEP_WAIT_US * `SSWC_CLK_MHZ)
`define SSWC_WAKE_HZ        4000
`define SSWC_WAKE_HALF_CYC  (`SSWC_CLK_MHZ * 1000000 / (2 * `SSWC_WAKE_HZ))
`define SSWC_WAKE_PERIODS   4
`define SSWC_TOP_WAIT_MS    50
`define SSWC_TOP_WAIT_CYC   (`SSWC_TOP_WAIT_MS * `SSWC_CLK_MHZ * 1000)
`define SSWC_WAKE_TMO_MS    100
`define SSWC_WAKE_TMO_CYC   (`SSWC_WAKE_TMO_MS * `SSWC_CLK_MHZ * 1000)
`define SSWC_LCLK_HALF      3
`define SSWC_FRAME_GAP      16

`define SSWC_ADDR_ALL       4'hf
`define SSWC_OP_SLEEP       4'h1
`define SSWC_OP_WAKE        4'h2
`define SSWC_RSP_NONE       2'h0
`define SSWC_RSP_ACK        2'h1
`define SSWC_RSP_NAK        2'h2

`endif

// ===== core/sswc_pkg.sv
// Types shared by both ends of the stack sleep and wake control.
package sswc_pkg;

  typedef enum logic [2:0] {
    SW_AWAKE    = 3'b000,
    SW_PEND     = 3'b001,
    SW_SLEEP    = 3'b010,
    SW_WAKE_TX  = 3'b011,
    SW_TOP_WAIT = 3'b100
  } sswc_state_t;

  typedef enum logic [1:0] {
    HS_IDLE  = 2'b00,
    HS_ARM   = 2'b01,
    HS_SHIFT = 2'b10,
    HS_GAP   = 2'b11
  } sswc_hstate_t;

endpackage

// ===== core/sswc_link_if.sv
// Serial command link between host and bottom stack device.
interface sswc_link_if;
  logic       link_clk;
  logic       frame;
  logic       sdi;
  logic [1:0] rsp_code;
  logic       rsp_tgl;

  modport host (output link_clk, output frame, output sdi,
                input rsp_code, input rsp_tgl);
  modport dev  (input link_clk, input frame, input sdi,
                output rsp_code, output rsp_tgl);
endinterface

// ===== core/sswc_dev.sv
// Device end: sleep entry, wake ripple and acknowledge sequencing.
`include "sswc_cfg.svh"
module sswc_dev
  import sswc_pkg::*;
#(
  parameter int unsigned SLEEP_WAIT_CYC = `SSWC_SLEEP_WAIT_CYC,
  parameter int unsigned WAKE_HALF_CYC  = `SSWC_WAKE_HALF_CYC,
  parameter int unsigned TOP_WAIT_CYC   = `SSWC_TOP_WAIT_CYC
) (
  input  wire logic       CLK_SYS_IN,    // Internal oscillator clock
  input  wire logic       RST_IN,        // Synchronous reset, high
  input  wire logic       IS_TOP_IN,     // Device is top of stack
  input  wire logic       IS_BOTTOM_IN,  // Device faces the host
  input  wire logic [3:0] DEV_ADDR_IN,   // Individual stack address
  input  wire logic [1:0] RATE_IN,       // 0:500k 1:250k 2:125k 3:62.5k
  input  wire logic       WDOG_EN_IN,    // Watchdog enabled
  input  wire logic       WDOG_EXP_IN,   // Watchdog expiry pulse
  input  wire logic       OSC_FAULT_IN,  // Oscillator fault pulse
  input  wire logic       SCAN_CONT_IN,  // Repeating scan active
  input  wire logic       SCAN_CYC_IN,   // Repeating scan cycle pulse
  input  wire logic       FAULT_IN,      // Fault found by scan, pulse
  input  wire logic       P1_CMD_IN,     // Valid command on port 1
  input  wire logic [7:0] P1_WORD_IN,    // Command word on port 1
  input  wire logic       P2_ACK_IN,     // Acknowledge from above
  input  wire logic       P1_WAKE_IN,    // Wake burst pin, port 1
  input  wire logic       P2_WAKE_IN,    // Wake burst pin, port 2
  output logic            SLEEP_OUT,     // Device asleep
  output logic            P1_WAKE_OUT,   // Wake burst out, port 1
  output logic            P2_WAKE_OUT,   // Wake burst out, port 2
  output logic            P1_ACK_OUT,    // Acknowledge down, pulse
  output logic            P1_NAK_OUT,    // Refusal down, pulse
  output logic            P1_IGN_OUT,    // Port 1 traffic ignored
  output logic            P2_IGN_OUT,    // Port 2 traffic ignored
  sswc_link_if.dev        LNK            // Host link
);

  ////////////////////////////////////////////////////////////////////
  // Link clock domain: command word capture
  logic [1:0] lrst_sync;
  logic       lrst;
  logic [7:0] l_sh;
  logic [7:0] next_l_sh;
  logic [2:0] l_cnt;
  logic [2:0] next_l_cnt;
  logic [7:0] l_word;
  logic [7:0] next_l_word;
  logic       l_tgl;
  logic       next_l_tgl;

  // Reset is brought into the link domain; host clock runs free
  always_ff @(posedge LNK.link_clk) begin
    lrst_sync <= {lrst_sync[0], RST_IN};
  end
  assign lrst = lrst_sync[1];

  always_comb begin
    next_l_sh   = l_sh;
    next_l_cnt  = l_cnt;
    next_l_word = l_word;
    next_l_tgl  = l_tgl;
    if (lrst) begin
      next_l_sh   = 8'h00;
      next_l_cnt  = 3'h0;
      next_l_word = 8'h00;
      next_l_tgl  = 1'b0;
    end else if (LNK.frame) begin
      next_l_sh  = {l_sh[6:0], LNK.sdi};
      next_l_cnt = l_cnt + 3'h1;
      if (l_cnt == 3'h7) begin
        next_l_word = {l_sh[6:0], LNK.sdi};
        next_l_tgl  = ~l_tgl;
      end
    end else begin
      next_l_cnt = 3'h0;
    end
  end

  always_ff @(posedge LNK.link_clk) begin
    l_sh   <= next_l_sh;
    l_cnt  <= next_l_cnt;
    l_word <= next_l_word;
    l_tgl  <= next_l_tgl;
  end

  ////////////////////////////////////////////////////////////////////
  // Crossings into the oscillator domain
  logic [2:0] tgl_s;
  logic [1:0] w1_s;
  logic [1:0] w2_s;

  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      tgl_s <= 3'h0;
      w1_s  <= 2'h0;
      w2_s  <= 2'h0;
    end else begin
      tgl_s <= {tgl_s[1:0], l_tgl};
      w1_s  <= {w1_s[0], P1_WAKE_IN};
      w2_s  <= {w2_s[0], P2_WAKE_IN};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Command decode
  logic       link_cmd;
  logic       cmd_v;
  logic [7:0] cw;
  logic       bcast;
  logic       mine;
  logic       is_slp;
  logic       is_wk;
  logic       sleep_now;
  logic       tx1;
  logic       tx2;

  // Word stays still until the next frame, so it is safe to read here
  assign link_cmd  = (tgl_s[2] ^ tgl_s[1]) & IS_BOTTOM_IN;
  assign cw        = link_cmd ? l_word : P1_WORD_IN;
  // Address checks are not gated by stack identification
  assign cmd_v     = (link_cmd | (P1_CMD_IN & ~IS_BOTTOM_IN)) & ~tx2;
  assign bcast     = cw[7:4] == `SSWC_ADDR_ALL;
  assign mine      = cw[7:4] == DEV_ADDR_IN;
  assign is_slp    = cw[3:0] == `SSWC_OP_SLEEP;
  assign is_wk     = cw[3:0] == `SSWC_OP_WAKE;
  assign sleep_now = (WDOG_EXP_IN & WDOG_EN_IN) | OSC_FAULT_IN;

  ////////////////////////////////////////////////////////////////////
  // Sleep and wake sequencer
  sswc_state_t state;
  sswc_state_t next_state;
  logic        scan_at;
  logic        next_scan_at;
  logic [22:0] wcnt;
  logic [22:0] next_wcnt;
  logic [13:0] div;
  logic [13:0] next_div;
  logic [3:0]  half;
  logic [3:0]  next_half;
  logic        wclk;
  logic        next_wclk;
  logic        next_tx1;
  logic        next_tx2;
  logic        top_after;
  logic        next_top_after;
  logic        do_ack;
  logic        do_nak;
  logic        go;
  logic        g1;
  logic        g2;
  logic        gtop;
  logic [22:0] wait_end;

  // Same number of chain periods at every rate
  assign wait_end = 23'(SLEEP_WAIT_CYC) << RATE_IN;

  always_comb begin
    next_state     = state;
    next_scan_at   = scan_at;
    next_wcnt      = wcnt;
    next_div       = div;
    next_half      = half;
    next_wclk      = wclk;
    next_tx1       = tx1;
    next_tx2       = tx2;
    next_top_after = top_after;
    do_ack         = 1'b0;
    do_nak         = 1'b0;
    go             = 1'b0;
    g1             = 1'b0;
    g2             = 1'b0;
    gtop           = 1'b0;
    // Only the addressed device refuses
    if (cmd_v && !bcast && mine && (is_slp || is_wk)) begin
      do_nak = 1'b1;
    end
    case (state)
      SW_AWAKE: begin
        if (sleep_now) begin
          next_state   = SW_SLEEP;
          next_scan_at = SCAN_CONT_IN;
        end else if (cmd_v && bcast && is_slp) begin
          next_state = SW_PEND;
          next_wcnt  = 23'h0;
          do_ack     = IS_TOP_IN;
        end
      end
      SW_PEND: begin
        // No link timeout runs here, only the delay
        if (sleep_now) begin
          next_state   = SW_SLEEP;
          next_scan_at = SCAN_CONT_IN;
        end else if (cmd_v && bcast && is_slp) begin
          next_wcnt = 23'h0;
          do_ack    = IS_TOP_IN;
        end else if (cmd_v) begin
          next_state = SW_AWAKE;
        end else if (wcnt >= wait_end - 23'h1) begin
          next_state   = SW_SLEEP;
          next_scan_at = SCAN_CONT_IN;
        end else begin
          next_wcnt = wcnt + 23'h1;
        end
      end
      SW_SLEEP: begin
        if (cmd_v && bcast && is_wk && IS_BOTTOM_IN) begin
          go   = 1'b1;
          g2   = ~IS_TOP_IN;
          gtop = IS_TOP_IN;
        end else if (w1_s[1] && !IS_BOTTOM_IN) begin
          go   = 1'b1;
          g2   = ~IS_TOP_IN;
          gtop = IS_TOP_IN;
        end else if (w2_s[1] && !IS_TOP_IN) begin
          go = 1'b1;
          g1 = ~IS_BOTTOM_IN;
        end else if (FAULT_IN && scan_at) begin
          go   = 1'b1;
          g1   = ~IS_BOTTOM_IN;
          g2   = ~IS_TOP_IN;
          gtop = IS_TOP_IN;
        end else if (SCAN_CYC_IN && scan_at) begin
          next_state = SW_AWAKE;
        end
      end
      SW_WAKE_TX: begin
        if (div == 14'(WAKE_HALF_CYC - 1)) begin
          next_div  = 14'h0;
          next_wclk = ~wclk;
          next_half = half + 4'h1;
          if (half == 4'(2 * `SSWC_WAKE_PERIODS - 1)) begin
            next_tx1   = 1'b0;
            next_tx2   = 1'b0;
            next_wclk  = 1'b0;
            next_wcnt  = 23'h0;
            next_state = top_after ? SW_TOP_WAIT : SW_AWAKE;
          end
        end else begin
          next_div = div + 14'h1;
        end
      end
      SW_TOP_WAIT: begin
        // Time for bursts started anywhere in the stack
        if (wcnt == 23'(TOP_WAIT_CYC - 1)) begin
          do_ack     = 1'b1;
          next_state = SW_AWAKE;
        end else begin
          next_wcnt = wcnt + 23'h1;
        end
      end
      default: next_state = SW_AWAKE;
    endcase
    if (go) begin
      next_tx1       = g1;
      next_tx2       = g2;
      next_top_after = gtop;
      next_div       = 14'h0;
      next_half      = 4'h0;
      next_wclk      = 1'b1;
      next_wcnt      = 23'h0;
      if (g1 || g2) begin
        next_state = SW_WAKE_TX;
      end else begin
        next_state = gtop ? SW_TOP_WAIT : SW_AWAKE;
      end
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      state     <= SW_AWAKE;
      scan_at   <= 1'b0;
      wcnt      <= 23'h0;
      div       <= 14'h0;
      half      <= 4'h0;
      wclk      <= 1'b0;
      tx1       <= 1'b0;
      tx2       <= 1'b0;
      top_after <= 1'b0;
    end else begin
      state     <= next_state;
      scan_at   <= next_scan_at;
      wcnt      <= next_wcnt;
      div       <= next_div;
      half      <= next_half;
      wclk      <= next_wclk;
      tx1       <= next_tx1;
      tx2       <= next_tx2;
      top_after <= next_top_after;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Responses and pins
  logic       link_ack;
  logic       link_nak;
  logic [1:0] next_code;

  // Acknowledge from above goes to host unless port 2 is muted
  assign link_ack  = IS_BOTTOM_IN & (do_ack | (P2_ACK_IN & ~tx1));
  assign link_nak  = IS_BOTTOM_IN & do_nak;
  assign next_code = link_ack ? `SSWC_RSP_ACK : (link_nak ? `SSWC_RSP_NAK : LNK.rsp_code);

  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      LNK.rsp_code <= `SSWC_RSP_NONE;
      LNK.rsp_tgl  <= 1'b0;
      SLEEP_OUT    <= 1'b0;
      P1_WAKE_OUT  <= 1'b0;
      P2_WAKE_OUT  <= 1'b0;
      P1_ACK_OUT   <= 1'b0;
      P1_NAK_OUT   <= 1'b0;
      P1_IGN_OUT   <= 1'b0;
      P2_IGN_OUT   <= 1'b0;
    end else begin
      LNK.rsp_code <= next_code;
      LNK.rsp_tgl  <= LNK.rsp_tgl ^ (link_ack | link_nak);
      SLEEP_OUT    <= next_state == SW_SLEEP;
      P1_WAKE_OUT  <= next_tx1 & next_wclk;
      P2_WAKE_OUT  <= next_tx2 & next_wclk;
      P1_ACK_OUT   <= do_ack & ~IS_BOTTOM_IN;
      P1_NAK_OUT   <= do_nak & ~IS_BOTTOM_IN;
      P1_IGN_OUT   <= next_tx2;
      P2_IGN_OUT   <= next_tx1;
    end
  end

endmodule

// ===== core/sswc_host.sv
// Host end: command serialiser, response capture and wake supervision.
`include "sswc_cfg.svh"
module sswc_host
  import sswc_pkg::*;
#(
  parameter int unsigned WAKE_TMO_CYC = `SSWC_WAKE_TMO_CYC
) (
  input  wire logic       CLK_SYS_IN,     // System clock
  input  wire logic       RST_IN,         // Synchronous reset, high
  input  wire logic       CMD_VALID_IN,   // Command request
  input  wire logic [7:0] CMD_WORD_IN,    // Address and opcode
  output logic            CMD_READY_OUT,  // Serialiser idle
  output logic            RSP_VALID_OUT,  // Response pulse
  output logic            RSP_ACK_OUT,    // Last response was ACK
  output logic            RSP_NAK_OUT,    // Last response was NAK
  output logic            WAKE_FAIL_OUT,  // No wake ACK in time, pulse
  output logic            UNSOL_ACK_OUT,  // ACK while asleep, pulse
  output logic            ASLEEP_OUT,     // Stack believed asleep
  sswc_link_if.host       LNK             // Link to bottom device
);

  ////////////////////////////////////////////////////////////////////
  // Link clock divider and serialiser
  sswc_hstate_t hs;
  sswc_hstate_t next_hs;
  logic [1:0]   ldiv;
  logic [1:0]   next_ldiv;
  logic         next_lclk;
  logic [7:0]   sh;
  logic [7:0]   next_sh;
  logic [3:0]   bits;
  logic [3:0]   next_bits;
  logic [4:0]   gap;
  logic [4:0]   next_gap;
  logic         next_frame;
  logic         next_sdi;
  logic         tick;
  logic         rise;
  logic         fall;

  assign tick = ldiv == 2'(`SSWC_LCLK_HALF - 1);
  assign rise = tick & ~LNK.link_clk;
  assign fall = tick & LNK.link_clk;

  always_comb begin
    next_hs    = hs;
    next_ldiv  = tick ? 2'h0 : ldiv + 2'h1;
    next_lclk  = tick ? ~LNK.link_clk : LNK.link_clk;
    next_sh    = sh;
    next_bits  = bits;
    next_gap   = gap;
    next_frame = LNK.frame;
    next_sdi   = LNK.sdi;
    case (hs)
      HS_IDLE: begin
        if (CMD_VALID_IN) begin
          next_sh = CMD_WORD_IN;
          next_hs = HS_ARM;
        end
      end
      HS_ARM: begin
        if (fall) begin
          next_frame = 1'b1;
          next_sdi   = sh[7];
          next_sh    = {sh[6:0], 1'b0};
          next_bits  = 4'h0;
          next_hs    = HS_SHIFT;
        end
      end
      HS_SHIFT: begin
        if (rise) begin
          next_bits = bits + 4'h1;
        end else if (fall) begin
          if (bits == 4'h8) begin
            next_frame = 1'b0;
            next_gap   = 5'h0;
            next_hs    = HS_GAP;
          end else begin
            next_sdi = sh[7];
            next_sh  = {sh[6:0], 1'b0};
          end
        end
      end
      HS_GAP: begin
        // Lets the device cross the word before the next frame
        if (gap == 5'(`SSWC_FRAME_GAP - 1)) begin
          next_hs = HS_IDLE;
        end else begin
          next_gap = gap + 5'h1;
        end
      end
      default: next_hs = HS_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      hs            <= HS_IDLE;
      ldiv          <= 2'h0;
      LNK.link_clk  <= 1'b0;
      sh            <= 8'h00;
      bits          <= 4'h0;
      gap           <= 5'h0;
      LNK.frame     <= 1'b0;
      LNK.sdi       <= 1'b0;
      CMD_READY_OUT <= 1'b0;
    end else begin
      hs            <= next_hs;
      ldiv          <= next_ldiv;
      LNK.link_clk  <= next_lclk;
      sh            <= next_sh;
      bits          <= next_bits;
      gap           <= next_gap;
      LNK.frame     <= next_frame;
      LNK.sdi       <= next_sdi;
      CMD_READY_OUT <= next_hs == HS_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Response capture and wake supervision
  logic [2:0]  r_s;
  logic        r_evt;
  logic        r_ack;
  logic        sent;
  logic        wk_cmd;
  logic        sl_cmd;
  logic        sl_wait;
  logic        next_sl_wait;
  logic        tmo_on;
  logic        next_tmo_on;
  logic [23:0] tmo;
  logic [23:0] next_tmo;
  logic        next_asleep;
  logic        fail;
  logic        unsol;

  assign r_evt  = r_s[2] ^ r_s[1];
  assign r_ack  = r_evt & (LNK.rsp_code == `SSWC_RSP_ACK);
  assign sent   = CMD_VALID_IN & (hs == HS_IDLE);
  assign wk_cmd = sent & (CMD_WORD_IN == {`SSWC_ADDR_ALL, `SSWC_OP_WAKE});
  assign sl_cmd = sent & (CMD_WORD_IN == {`SSWC_ADDR_ALL, `SSWC_OP_SLEEP});

  always_comb begin
    next_sl_wait = sl_wait;
    next_tmo_on  = tmo_on;
    next_tmo     = tmo;
    next_asleep  = ASLEEP_OUT;
    fail         = 1'b0;
    unsol        = 1'b0;
    if (wk_cmd) begin
      next_tmo_on = 1'b1;
      next_tmo    = 24'h0;
    end else if (tmo_on && r_ack) begin
      next_tmo_on = 1'b0;
      next_asleep = 1'b0;
    end else if (tmo_on) begin
      // Missing ACK is the only sign of a broken chain
      if (tmo == 24'(WAKE_TMO_CYC - 1)) begin
        next_tmo_on = 1'b0;
        fail        = 1'b1;
      end else begin
        next_tmo = tmo + 24'h1;
      end
    end else if (ASLEEP_OUT && r_ack) begin
      unsol       = 1'b1;
      next_asleep = 1'b0;
    end
    if (sl_cmd) begin
      next_sl_wait = 1'b1;
    end else if (sent) begin
      next_sl_wait = 1'b0;
    end else if (sl_wait && r_evt) begin
      next_sl_wait = 1'b0;
      next_asleep  = r_ack;
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      r_s           <= 3'h0;
      sl_wait       <= 1'b0;
      tmo_on        <= 1'b0;
      tmo           <= 24'h0;
      ASLEEP_OUT    <= 1'b0;
      RSP_VALID_OUT <= 1'b0;
      RSP_ACK_OUT   <= 1'b0;
      RSP_NAK_OUT   <= 1'b0;
      WAKE_FAIL_OUT <= 1'b0;
      UNSOL_ACK_OUT <= 1'b0;
    end else begin
      r_s           <= {r_s[1:0], LNK.rsp_tgl};
      sl_wait       <= next_sl_wait;
      tmo_on        <= next_tmo_on;
      tmo           <= next_tmo;
      ASLEEP_OUT    <= next_asleep;
      RSP_VALID_OUT <= r_evt;
      RSP_ACK_OUT   <= r_evt ? r_ack : RSP_ACK_OUT;
      RSP_NAK_OUT   <= r_evt ? (LNK.rsp_code == `SSWC_RSP_NAK) : RSP_NAK_OUT;
      WAKE_FAIL_OUT <= fail;
      UNSOL_ACK_OUT <= unsol;
    end
  end

endmodule

// ===== verif/sswc_properties.sv
// Checks on the link and on the device end of the sleep and wake control.
module sswc_checker (
  input wire logic       CLK_SYS_IN,   // Clock
  input wire logic       RST_IN,       // Device reset
  input wire logic       frame,        // Link frame
  input wire logic       rsp_tgl,      // Response toggle
  input wire logic [1:0] rsp_code,     // Response code
  input wire logic       IS_TOP_IN,    // Top strap
  input wire logic       IS_BOTTOM_IN, // Bottom strap
  input wire logic [3:0] DEV_ADDR_IN,  // Own address
  input wire logic       WDOG_EN_IN,   // Watchdog on
  input wire logic       WDOG_EXP_IN,  // Watchdog pulse
  input wire logic       P1_CMD_IN,    // Port 1 command
  input wire logic [7:0] P1_WORD_IN,   // Port 1 word
  input wire logic       SLEEP_OUT,    // Asleep
  input wire logic       P1_WAKE_OUT,  // Burst port 1
  input wire logic       P2_WAKE_OUT,  // Burst port 2
  input wire logic       P1_ACK_OUT,   // Ack pulse
  input wire logic       P1_NAK_OUT,   // Nak pulse
  input wire logic       P1_IGN_OUT,   // Port 1 ignored
  input wire logic       P2_IGN_OUT    // Port 2 ignored
);
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (RST_IN);
  ////////////////////////////////////////////////////////////////////////////////
  property p_frame; $rose(frame) |-> ##46 frame ##[1:3] !frame; endproperty
  property p_code; $changed(rsp_tgl) |-> rsp_code inside {2'h1, 2'h2}; endproperty
  property p_ign1; $rose(P2_WAKE_OUT) |-> ##[0:1] P1_IGN_OUT; endproperty
  property p_ign2; $rose(P1_WAKE_OUT) |-> ##[0:1] P2_IGN_OUT; endproperty
  property p_burst; $rose(P2_WAKE_OUT) |-> P2_WAKE_OUT[*4] ##1 !P2_WAKE_OUT; endproperty
  property p_wdog; WDOG_EN_IN && WDOG_EXP_IN |-> ##[1:3] SLEEP_OUT; endproperty
  // Only an awake, listening top device that is not bottom must answer
  property p_ack;
    IS_TOP_IN && !IS_BOTTOM_IN && P1_CMD_IN && P1_WORD_IN == 8'hf1 && !SLEEP_OUT && !P1_IGN_OUT
      |-> ##[1:6] P1_ACK_OUT;
  endproperty
  property p_nak;
    !IS_BOTTOM_IN && P1_CMD_IN && P1_WORD_IN == {DEV_ADDR_IN, 4'h1} && DEV_ADDR_IN != 4'hf
      && !SLEEP_OUT && !P1_IGN_OUT |-> ##[1:6] P1_NAK_OUT;
  endproperty
  ////////////////////////////////////////////////////////////////////////////////
  a_frame: assert property (p_frame) else $error("frame length");
  a_code: assert property (p_code) else $error("bad response code");
  a_ign1: assert property (p_ign1) else $error("port 1 not ignored");
  a_ign2: assert property (p_ign2) else $error("port 2 not ignored");
  a_burst: assert property (p_burst) else $error("burst shape");
  a_wdog: assert property (p_wdog) else $error("no watchdog sleep");
  a_ack: assert property (p_ack) else $error("no sleep ack");
  a_nak: assert property (p_nak) else $error("no nak");
  c_sleep: cover property ($rose(SLEEP_OUT));
  c_burst: cover property ($rose(P2_WAKE_OUT));
  c_nak: cover property ($rose(P1_NAK_OUT));
endmodule

// ===== verif/stack_sleep_wake_control_test.sv
// Bench joining host and device ends over the link.
module stack_sleep_wake_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SLP = 20;
  localparam int TOPW = 200;
  logic       clk = 1'b0, rst_h = 1'b1, rst_d = 1'b1, cmd_v = 1'b0, got = 1'b0, wd_en = 1'b1;
  logic [7:0] cmd_w = 8'h00, last = 8'h00, p1_word = 8'h00, sh = 8'h00;
  logic       top = 1'b1, bot = 1'b1, wd_exp = 1'b0, osc = 1'b0, sc = 1'b0, sy = 1'b0;
  logic       flt = 1'b0, p1_cmd = 1'b0, p2_ack = 1'b0, p1_wk = 1'b0, p2_wk = 1'b0;
  logic [3:0] addr = 4'h3;
  logic [1:0] rate = 2'h0;
  logic       slp, b1, b2, ack, nak, i1, i2, rdy, rv, rack, rnak, wf, aslp, un;
  int         err_count = 0, checks = 0, cyc = 0, n_un = 0;
  int         n_ack = 0, n_nak = 0, n_b1 = 0, n_b2 = 0, n_i1 = 0, n_i2 = 0, n_wf = 0, n_rv = 0;
  sswc_link_if lnk ();
  sswc_host #(.WAKE_TMO_CYC(1000)) u_sswc_host (.CLK_SYS_IN(clk), .RST_IN(rst_h),
    .CMD_VALID_IN(cmd_v), .CMD_WORD_IN(cmd_w), .CMD_READY_OUT(rdy), .RSP_VALID_OUT(rv),
    .RSP_ACK_OUT(rack), .RSP_NAK_OUT(rnak), .WAKE_FAIL_OUT(wf), .UNSOL_ACK_OUT(un),
    .ASLEEP_OUT(aslp), .LNK(lnk.host));
  sswc_dev #(.SLEEP_WAIT_CYC(SLP), .WAKE_HALF_CYC(4), .TOP_WAIT_CYC(TOPW)) u_sswc_dev (
    .CLK_SYS_IN(clk), .RST_IN(rst_d), .IS_TOP_IN(top), .IS_BOTTOM_IN(bot), .DEV_ADDR_IN(addr),
    .RATE_IN(rate), .WDOG_EN_IN(wd_en), .WDOG_EXP_IN(wd_exp), .OSC_FAULT_IN(osc),
    .SCAN_CONT_IN(sc), .SCAN_CYC_IN(sy), .FAULT_IN(flt), .P1_CMD_IN(p1_cmd),
    .P1_WORD_IN(p1_word), .P2_ACK_IN(p2_ack), .P1_WAKE_IN(p1_wk), .P2_WAKE_IN(p2_wk),
    .SLEEP_OUT(slp), .P1_WAKE_OUT(b1), .P2_WAKE_OUT(b2), .P1_ACK_OUT(ack), .P1_NAK_OUT(nak),
    .P1_IGN_OUT(i1), .P2_IGN_OUT(i2), .LNK(lnk.dev));
  sswc_checker u_chk (.CLK_SYS_IN(clk), .RST_IN(rst_d), .frame(lnk.frame),
    .rsp_tgl(lnk.rsp_tgl), .rsp_code(lnk.rsp_code), .IS_TOP_IN(top), .IS_BOTTOM_IN(bot),
    .DEV_ADDR_IN(addr), .WDOG_EN_IN(wd_en), .WDOG_EXP_IN(wd_exp), .P1_CMD_IN(p1_cmd),
    .P1_WORD_IN(p1_word), .SLEEP_OUT(slp), .P1_WAKE_OUT(b1), .P2_WAKE_OUT(b2),
    .P1_ACK_OUT(ack), .P1_NAK_OUT(nak), .P1_IGN_OUT(i1), .P2_IGN_OUT(i2));
  ////////////////////////////////////////////////////////////////////////////////
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    n_ack <= n_ack + int'(ack === 1'b1);
    n_nak <= n_nak + int'(nak === 1'b1);
    n_b1 <= n_b1 + int'(b1 === 1'b1);
    n_b2 <= n_b2 + int'(b2 === 1'b1);
    n_i1 <= n_i1 + int'(i1 === 1'b1);
    n_i2 <= n_i2 + int'(i2 === 1'b1);
    n_wf <= n_wf + int'(wf === 1'b1);
    n_rv <= n_rv + int'(rv === 1'b1);
    n_un <= n_un + int'(un === 1'b1);
    if (cyc == 30000) begin
      err_count++;
      conclude();
    end
  end
  // Byte seen on the wire, MSB first
  always @(posedge lnk.link_clk) if (lnk.frame === 1'b1) sh <= {sh[6:0], lnk.sdi};
  always @(negedge lnk.frame) check(sh, last);
  ////////////////////////////////////////////////////////////////////////////////
  function automatic int slp_cyc(input int r);
    return SLP << r;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Host reset first, since its link clock stands still in reset
  task automatic reset_all();
    rst_h <= 1'b1;
    rst_d <= 1'b1;
    tick(20);
    rst_h <= 1'b0;
    tick(20);
    rst_d <= 1'b0;
    // Link side leaves reset only two link clocks later
    tick(24);
  endtask
  task automatic hcmd(input logic [7:0] w);
    while (rdy !== 1'b1) tick(1);
    cmd_v <= 1'b1;
    cmd_w <= w;
    last <= w;
    tick(1);
    while (rdy !== 1'b1) tick(1);
    cmd_v <= 1'b0;
  endtask
  task automatic wait_rsp();
    int n0;
    n0 = n_rv;
    for (int i = 0; i < 2000 && n_rv == n0; i++) tick(1);
    got = (n_rv != n0);
  endtask
  task automatic p1cmd(input logic [7:0] w);
    p1_cmd <= 1'b1;
    p1_word <= w;
    tick(1);
    p1_cmd <= 1'b0;
  endtask
  task automatic pulse(input int k);
    case (k)
      0: wd_exp <= 1'b1;
      1: osc <= 1'b1;
      2: flt <= 1'b1;
      default: sy <= 1'b1;
    endcase
    tick(1);
    {wd_exp, osc, flt, sy} <= 4'h0;
  endtask
  task automatic burst_in(input logic two);
    if (two) p2_wk <= 1'b1;
    else p1_wk <= 1'b1;
    tick(8);
    {p1_wk, p2_wk} <= 2'b00;
  endtask
  task automatic conclude();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    int w;
    int a;
    n = $urandom(45263);
    addr <= 4'($urandom_range(14));
    reset_all();
    hcmd({addr, 4'h1});
    wait_rsp();
    check({got, rack, rnak, slp}, 4'b1010);
    hcmd(8'hf1);
    wait_rsp();
    check({got, rack, aslp}, 3'b111);
    for (w = 0; w < 200 && slp !== 1'b1; w++) tick(1);
    check(slp, 1'b1);
    p2_ack <= 1'b1;
    tick(1);
    p2_ack <= 1'b0;
    wait_rsp();
    check({got, n_un == 1, aslp}, 3'b110);
    hcmd({addr, 4'h2});
    wait_rsp();
    check({got, rnak, slp}, 3'b111);
    hcmd(8'hf2);
    wait_rsp();
    check({got, rack, slp, n_wf == 0}, 4'b1101);
    bot <= 1'b0;
    for (int r = 0; r < 4; r++) begin
      rate <= r[1:0];
      n = n_ack;
      p1cmd(8'hf1);
      for (w = 0; w < 1000 && slp !== 1'b1; w++) tick(1);
      check({n_ack != n, w >= slp_cyc(r) - 2, w <= slp_cyc(r) + 8}, 3'b111);
      n = n_ack;
      burst_in(1'b0);
      for (w = 0; w < 400 && n_ack == n; w++) tick(1);
      check({w >= TOPW - 12, w <= TOPW + 12}, 2'b11);
    end
    p1cmd(8'hf1);
    tick(100);
    p1cmd(8'hf1);
    tick(100);
    check(slp, 1'b0);
    tick(80);
    check(slp, 1'b1);
    burst_in(1'b0);
    tick(300);
    p1cmd(8'hf1);
    tick(40);
    p1cmd({4'($urandom_range(15)), 4'h3});
    tick(400);
    check(slp, 1'b0);
    top <= 1'b0;
    reset_all();
    wd_en <= 1'b0;
    n = n_nak;
    pulse(0);
    p1cmd({addr, 4'h1});
    tick(3);
    check({slp, n_nak != n}, 2'b01);
    wd_en <= 1'b1;
    pulse(0);
    tick(3);
    check(slp, 1'b1);
    n = n_nak;
    burst_in(1'b0);
    p1cmd({addr, 4'h1});
    tick(40);
    check({slp, n_b2 > 0, n_i1 > 0, n_nak == n}, 4'b0111);
    sc <= 1'b1;
    pulse(1);
    tick(3);
    check(slp, 1'b1);
    n = n_b1;
    a = n_b2;
    pulse(2);
    tick(40);
    check({slp, n_b1 != n, n_b2 != a}, 3'b011);
    pulse(1);
    tick(3);
    n = n_i2;
    burst_in(1'b1);
    tick(40);
    check({slp, n_i2 != n}, 2'b01);
    pulse(1);
    tick(3);
    n = n_b1 + n_b2;
    pulse(3);
    tick(40);
    check({slp, n_b1 + n_b2 == n}, 2'b01);
    bot <= 1'b1;
    reset_all();
    pulse(0);
    tick(2);
    n = n_b2;
    hcmd(8'hf2);
    tick(100);
    check({slp, n_b2 != n}, 2'b01);
    p2_ack <= 1'b1;
    tick(1);
    p2_ack <= 1'b0;
    wait_rsp();
    check({got, rack}, 2'b11);
    pulse(0);
    tick(2);
    n = n_wf;
    hcmd(8'hf2);
    tick(1100);
    check(n_wf != n, 1'b1);
    conclude();
  end
endmodule
